// ---- common/cpu_int_pkg.sv ----
package cpu_int_pkg;

  // ==========================================================================
  // register map: printed offsets are indices, byte address is four times
  // ==========================================================================
  localparam logic [1:0] IDX_VECTOR_CONTROL = 2'h0;
  localparam logic [1:0] IDX_EXECUTING_LEVEL_FLAGS = 2'h1;
  localparam logic [1:0] IDX_LAST_LOW_LEVEL_VECTOR = 2'h2;
  localparam logic [1:0] IDX_HIGH_LEVEL_VECTOR_SELECT = 2'h3;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int unsigned POS_PLACEMENT = 6;
  localparam int unsigned POS_COMPACT = 5;
  localparam int unsigned POS_ROUND_ROBIN = 0;
  localparam int unsigned POS_NMI_EX = 7;
  localparam int unsigned POS_HIGH_EX = 1;
  localparam int unsigned POS_LOW_EX = 0;

  // ==========================================================================
  // reset values and encodings
  // ==========================================================================
  localparam logic [7:0] RST_VECTOR_CONTROL = 8'h00;
  localparam logic [7:0] RST_LAST_LOW_LEVEL_VECTOR = 8'h00;
  localparam logic [7:0] RST_HIGH_LEVEL_VECTOR_SELECT = 8'h00;
  localparam logic [7:0] HIGH_LEVEL_DISABLED = 8'h00;
  localparam logic [7:0] COMPACT_NMI_VECTOR = 8'h01;
  localparam logic [7:0] COMPACT_HIGH_VECTOR = 8'h02;
  localparam logic [7:0] COMPACT_LOW_VECTOR = 8'h03;
  localparam logic [15:0] APP_TABLE_BASE = 16'h0100;
  localparam logic [15:0] BOOT_TABLE_BASE = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {LEVEL_LOW, LEVEL_HIGH, LEVEL_NMI} level_e;

  typedef struct packed {
    logic valid;
    level_e level;
    logic [7:0] vector;
  } offer_s;

  typedef struct packed {
    logic placement;
    logic compact;
    logic round_robin;
  } ctrl_s;

endpackage

// ---- core/low_level_arbiter.sv ----
`timescale 1ns/10ps
`default_nettype none

module low_level_arbiter #(
  parameter int unsigned NVEC = 32
) (
  input wire logic [NVEC-1:0] req,
  input wire logic round_robin,
  input wire logic [7:0] last_vec,
  output logic grant_valid,
  output logic [7:0] grant_vec
);

  // ==========================================================================
  // lowest-index search, over all and over those above the last served
  // ==========================================================================
  logic [NVEC:0] seen_all;
  logic [NVEC:0] seen_up;
  logic [7:0] idx_all [NVEC+1];
  logic [7:0] idx_up [NVEC+1];
  logic use_up;

  assign seen_all[0] = 1'b0;
  assign seen_up[0] = 1'b0;
  assign idx_all[0] = 8'h00;
  assign idx_up[0] = 8'h00;

  genvar i;
  generate
    for (i = 0; i < NVEC; i++) begin : g_entry
      logic up_req;
      assign up_req = req[i] && (8'(i) > last_vec);
      assign seen_all[i+1] = seen_all[i] | req[i];
      assign seen_up[i+1] = seen_up[i] | up_req;
      assign idx_all[i+1] = idx_all[i] | ((req[i] && !seen_all[i]) ? 8'(i) : 8'h00);
      assign idx_up[i+1] = idx_up[i] | ((up_req && !seen_up[i]) ? 8'(i) : 8'h00);
    end
  endgenerate

  // wrap to the lowest request when nothing lies above the last served
  assign use_up = round_robin && seen_up[NVEC];
  assign grant_valid = seen_all[NVEC];
  assign grant_vec = use_up ? idx_up[NVEC] : idx_all[NVEC];

endmodule // low_level_arbiter

`default_nettype wire

// ---- core/cpu_interrupt_priority_regs.sv ----
// Operation
// - placement bit 6: 0 puts vectors at application start, 1 at boot start.
// - compact bit 5 turns the three-entry compact vector table off or on.
// - placement and compact bits change only on writes with protection unlocked.
// - round-robin bit 0 takes ordinary writes, no unlock needed.
// - round-robin off: lowest low-level vector wins; on: rotating priority.
// - round-robin on: acknowledged low vector is captured and goes last next time.
// - after reset the lowest low-level vector has highest priority.
// - high-level select register holds the one vector promoted to high level.
// - select value zero means no high-level vector; high level disabled.
// - status bit 7 set while the non-maskable handler runs, cleared on return.
// - status bit 1 set during high handler, kept under non-maskable, cleared on return.
// - status bit 0 set during low handler, kept when preempted, cleared on return.
// - compact table: non-maskable vector 1, high level 2, all low level 3.
// - high request preempts a low handler; low handler resumes afterwards.
// - nothing preempts a running non-maskable handler.
`timescale 1ns/10ps
`default_nettype none

module cpu_interrupt_priority_regs #(
  parameter int unsigned NVEC = 32,
  parameter int unsigned ADDR_W = 8,
  parameter logic [15:0] APP_BASE = cpu_int_pkg::APP_TABLE_BASE,
  parameter logic [15:0] BOOT_BASE = cpu_int_pkg::BOOT_TABLE_BASE
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [NVEC-1:0] irq_req,
  input wire logic nmi_req,
  input wire logic change_protection_unlock,
  input wire logic irq_ack,
  input wire logic return_from_handler,
  output cpu_int_pkg::offer_s irq_offer,
  output logic [15:0] irq_table_addr,
  output cpu_int_pkg::ctrl_s vector_control_bits
);

  // ==========================================================================
  // state
  // ==========================================================================
  cpu_int_pkg::ctrl_s ctrl_r;
  logic [7:0] last_vec_r;
  logic [7:0] high_vec_r;
  logic nmi_ex_r;
  logic high_ex_r;
  logic low_ex_r;
  cpu_int_pkg::offer_s offer_r;
  logic [15:0] table_r;
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_strb0_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // ==========================================================================
  // bus decode
  // ==========================================================================
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic wr_hit;
  logic [1:0] wr_idx;
  logic wr_low;
  logic wr_ctrl;
  logic wr_last;
  logic wr_high;
  logic ar_take;
  logic rd_hit;
  logic [1:0] rd_idx;
  logic [7:0] status_byte;
  logic [7:0] ctrl_byte;
  logic [7:0] rd_byte;

  assign aw_take = awvalid && awready_r;
  assign w_take = wvalid && wready_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign wr_hit = (aw_addr_r[ADDR_W-1:4] == '0) && (aw_addr_r[1:0] == 2'h0);
  assign wr_idx = aw_addr_r[3:2];
  assign wr_low = wr_fire && wr_hit && w_strb0_r;
  assign wr_ctrl = wr_low && (wr_idx == cpu_int_pkg::IDX_VECTOR_CONTROL);
  assign wr_last = wr_low && (wr_idx == cpu_int_pkg::IDX_LAST_LOW_LEVEL_VECTOR);
  assign wr_high = wr_low && (wr_idx == cpu_int_pkg::IDX_HIGH_LEVEL_VECTOR_SELECT);
  assign ar_take = arvalid && arready_r;
  assign rd_hit = (araddr[ADDR_W-1:4] == '0) && (araddr[1:0] == 2'h0);
  assign rd_idx = araddr[3:2];

  always_comb begin
    status_byte = 8'h00;
    status_byte[cpu_int_pkg::POS_NMI_EX] = nmi_ex_r;
    status_byte[cpu_int_pkg::POS_HIGH_EX] = high_ex_r;
    status_byte[cpu_int_pkg::POS_LOW_EX] = low_ex_r;
    ctrl_byte = 8'h00;
    ctrl_byte[cpu_int_pkg::POS_PLACEMENT] = ctrl_r.placement;
    ctrl_byte[cpu_int_pkg::POS_COMPACT] = ctrl_r.compact;
    ctrl_byte[cpu_int_pkg::POS_ROUND_ROBIN] = ctrl_r.round_robin;
  end

  assign rd_byte = (rd_idx == cpu_int_pkg::IDX_VECTOR_CONTROL) ? ctrl_byte :
                   (rd_idx == cpu_int_pkg::IDX_EXECUTING_LEVEL_FLAGS) ? status_byte :
                   (rd_idx == cpu_int_pkg::IDX_LAST_LOW_LEVEL_VECTOR) ? last_vec_r :
                   high_vec_r;

  // ==========================================================================
  // control register next value
  // ==========================================================================
  cpu_int_pkg::ctrl_s ctrl_nxt;
  logic unlocked_wr;

  assign unlocked_wr = wr_ctrl && change_protection_unlock;
  assign ctrl_nxt.placement = unlocked_wr ? w_data_r[cpu_int_pkg::POS_PLACEMENT]
                                          : ctrl_r.placement;
  assign ctrl_nxt.compact = unlocked_wr ? w_data_r[cpu_int_pkg::POS_COMPACT]
                                        : ctrl_r.compact;
  assign ctrl_nxt.round_robin = wr_ctrl ? w_data_r[cpu_int_pkg::POS_ROUND_ROBIN]
                                        : ctrl_r.round_robin;

  // ==========================================================================
  // candidate selection
  // ==========================================================================
  logic [255:0] req_wide;
  logic [NVEC-1:0] high_onehot;
  logic [NVEC-1:0] low_req;
  logic high_enabled;
  logic high_req;
  logic nmi_cand;
  logic high_cand;
  logic low_cand;
  logic grant_valid;
  logic [7:0] grant_vec;
  logic any_ex;
  logic ack_take;
  cpu_int_pkg::offer_s offer_nxt;
  logic [7:0] entry;
  logic [15:0] base;
  logic [15:0] table_nxt;

  assign req_wide = 256'(irq_req);
  assign high_enabled = high_vec_r != cpu_int_pkg::HIGH_LEVEL_DISABLED;
  assign high_req = high_enabled && req_wide[high_vec_r];
  assign high_onehot = high_enabled ? ({{(NVEC-1){1'b0}}, 1'b1} << high_vec_r) : '0;
  assign low_req = irq_req & ~high_onehot & ~{{(NVEC-1){1'b0}}, 1'b1};
  assign any_ex = nmi_ex_r || high_ex_r || low_ex_r;

  low_level_arbiter #(
    .NVEC(NVEC)
  ) u_arbiter (
    .req(low_req),
    .round_robin(ctrl_r.round_robin),
    .last_vec(last_vec_r),
    .grant_valid(grant_valid),
    .grant_vec(grant_vec)
  );

  assign nmi_cand = nmi_req && !nmi_ex_r;
  assign high_cand = high_req && !nmi_ex_r && !high_ex_r;
  assign low_cand = grant_valid && !any_ex;
  assign ack_take = irq_ack && offer_r.valid;

  always_comb begin
    offer_nxt.valid = 1'b0;
    offer_nxt.level = cpu_int_pkg::LEVEL_LOW;
    offer_nxt.vector = grant_vec;
    entry = grant_vec;
    if (nmi_cand) begin
      offer_nxt.valid = 1'b1;
      offer_nxt.level = cpu_int_pkg::LEVEL_NMI;
      offer_nxt.vector = cpu_int_pkg::COMPACT_NMI_VECTOR;
      entry = cpu_int_pkg::COMPACT_NMI_VECTOR;
    end else if (high_cand) begin
      offer_nxt.valid = 1'b1;
      offer_nxt.level = cpu_int_pkg::LEVEL_HIGH;
      offer_nxt.vector = high_vec_r;
      entry = ctrl_r.compact ? cpu_int_pkg::COMPACT_HIGH_VECTOR : high_vec_r;
    end else if (low_cand) begin
      offer_nxt.valid = 1'b1;
      entry = ctrl_r.compact ? cpu_int_pkg::COMPACT_LOW_VECTOR : grant_vec;
    end
    // no new offer in the cycle the previous one is acknowledged
    if (ack_take) begin
      offer_nxt.valid = 1'b0;
    end
  end

  assign base = ctrl_r.placement ? BOOT_BASE : APP_BASE;
  assign table_nxt = base + {8'h00, entry};

  // ==========================================================================
  // executing flags: clear highest on return, then set on acknowledge
  // ==========================================================================
  logic nmi_ex_nxt;
  logic high_ex_nxt;
  logic low_ex_nxt;
  logic ack_nmi;
  logic ack_high;
  logic ack_low;

  assign ack_nmi = ack_take && (offer_r.level == cpu_int_pkg::LEVEL_NMI);
  assign ack_high = ack_take && (offer_r.level == cpu_int_pkg::LEVEL_HIGH);
  assign ack_low = ack_take && (offer_r.level == cpu_int_pkg::LEVEL_LOW);

  always_comb begin
    nmi_ex_nxt = nmi_ex_r;
    high_ex_nxt = high_ex_r;
    low_ex_nxt = low_ex_r;
    if (return_from_handler) begin
      if (nmi_ex_r) begin
        nmi_ex_nxt = 1'b0;
      end else if (high_ex_r) begin
        high_ex_nxt = 1'b0;
      end else begin
        low_ex_nxt = 1'b0;
      end
    end
    if (ack_nmi) begin
      nmi_ex_nxt = 1'b1;
    end
    if (ack_high) begin
      high_ex_nxt = 1'b1;
    end
    if (ack_low) begin
      low_ex_nxt = 1'b1;
    end
  end

  logic [7:0] last_vec_nxt;

  assign last_vec_nxt = (ack_low && ctrl_r.round_robin) ? offer_r.vector :
                        wr_last ? w_data_r : last_vec_r;

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= cpu_int_pkg::ctrl_s'(3'h0);
      last_vec_r <= cpu_int_pkg::RST_LAST_LOW_LEVEL_VECTOR;
      high_vec_r <= cpu_int_pkg::RST_HIGH_LEVEL_VECTOR_SELECT;
      nmi_ex_r <= 1'b0;
      high_ex_r <= 1'b0;
      low_ex_r <= 1'b0;
      offer_r <= '0;
      table_r <= 16'h0000;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      last_vec_r <= last_vec_nxt;
      high_vec_r <= wr_high ? w_data_r : high_vec_r;
      nmi_ex_r <= nmi_ex_nxt;
      high_ex_r <= high_ex_nxt;
      low_ex_r <= low_ex_nxt;
      offer_r <= offer_nxt;
      table_r <= table_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 8'h00;
      w_strb0_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= cpu_int_pkg::RESP_OKAY;
    end else if (ce) begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr;
        awready_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        w_data_r <= wdata[7:0];
        w_strb0_r <= wstrb[0];
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? cpu_int_pkg::RESP_OKAY : cpu_int_pkg::RESP_DECERR;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= cpu_int_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        rresp_r <= rd_hit ? cpu_int_pkg::RESP_OKAY : cpu_int_pkg::RESP_DECERR;
      end else if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign irq_offer = offer_r;
  assign irq_table_addr = table_r;
  assign vector_control_bits = ctrl_r;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_protected_hold: assert property (ce && wr_ctrl && !change_protection_unlock |=>
      $stable(ctrl_r.placement) && $stable(ctrl_r.compact))
    else $error("protected bit changed without unlock");

  a_round_robin_write: assert property (ce && wr_ctrl |=>
      ctrl_r.round_robin == $past(w_data_r[cpu_int_pkg::POS_ROUND_ROBIN]))
    else $error("round-robin bit not written");

  a_capture_last: assert property (ce && ack_low && ctrl_r.round_robin |=>
      last_vec_r == $past(offer_r.vector))
    else $error("acknowledged low vector not captured");

  a_high_disabled: assert property (offer_r.valid && offer_r.level == cpu_int_pkg::LEVEL_HIGH |->
      $past(high_vec_r) != cpu_int_pkg::HIGH_LEVEL_DISABLED)
    else $error("high level offered while disabled");

  a_nmi_flag_set: assert property (ce && ack_nmi |=> nmi_ex_r)
    else $error("non-maskable flag not set on acknowledge");

  a_low_kept: assert property (ce && return_from_handler && nmi_ex_r && low_ex_r
      && !ack_take |=> low_ex_r && !nmi_ex_r)
    else $error("return cleared the wrong level");

  a_compact_low: assert property (offer_r.valid && offer_r.level == cpu_int_pkg::LEVEL_LOW
      && $past(ce) && $past(ctrl_r.compact) |->
      table_r == $past(base) + 16'h0003)
    else $error("compact low entry wrong");

  a_nmi_no_preempt: assert property (nmi_ex_r ##1 nmi_ex_r |->
      !(offer_r.valid && offer_r.level != cpu_int_pkg::LEVEL_NMI))
    else $error("offer made during non-maskable handler");

  a_high_preempts: assert property (ce && !ack_take && low_ex_r && !high_ex_r && !nmi_ex_r
      && high_req && !nmi_req |=> offer_r.valid && offer_r.level == cpu_int_pkg::LEVEL_HIGH)
    else $error("high request did not preempt low handler");

  c_nmi_ack: cover property (ce && ack_nmi);
  c_high_over_low: cover property (ce && ack_high && low_ex_r);
  c_round_robin_capture: cover property (ce && ack_low && ctrl_r.round_robin);
  c_unlocked_write: cover property (ce && unlocked_wr);

endmodule // cpu_interrupt_priority_regs

`default_nettype wire

// ---- verif/core_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// core side: takes offers, opens the unlock window
// ============================================================
module core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire cpu_int_pkg::offer_s irq_offer,
  input wire logic ack_en,
  input wire logic key_write,
  output logic irq_ack,
  output logic change_protection_unlock
);
  logic [2:0] key_cnt_r;
  logic [2:0] key_cnt_nxt;

  // key opens a four-cycle window for protected writes
  assign key_cnt_nxt = key_write ? 3'h4 : key_cnt_r - {2'h0, key_cnt_r != 3'h0};
  assign change_protection_unlock = key_cnt_r != 3'h0;
  // only an offer that stands is acknowledged
  assign irq_ack = ack_en & irq_offer.valid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_cnt_r <= 3'h0;
    end else begin
      key_cnt_r <= key_cnt_nxt;
    end
  end
endmodule // core_model

`default_nettype wire

// ---- verif/test_cpu_interrupt_priority_regs.sv ----
`timescale 1ns/10ps
`default_nettype none

module test_cpu_interrupt_priority_regs;
  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, nmi_req, unlock, irq_ack, ret;
  logic ack_en, key_write, plc_on, cmp_on;
  logic [7:0] awaddr, araddr, last, x;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  logic [31:0] wdata, rdata, irq_req, d, q;
  logic [1:0] bresp, rresp, r;
  logic [15:0] taddr;
  cpu_int_pkg::offer_s irq_offer;
  cpu_int_pkg::ctrl_s cbits;
  int errors, cmp_count, seed;

  cpu_interrupt_priority_regs cpu_interrupt_priority_regs_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq_req(irq_req), .nmi_req(nmi_req),
    .change_protection_unlock(unlock), .irq_ack(irq_ack),
    .return_from_handler(ret), .irq_offer(irq_offer), .irq_table_addr(taddr),
    .vector_control_bits(cbits));

  core_model core_model_inst (
    .aclk(aclk), .aresetn(aresetn), .irq_offer(irq_offer), .ack_en(ack_en),
    .key_write(key_write), .irq_ack(irq_ack), .change_protection_unlock(unlock));

  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  // ============================================================
  // checks and expectations
  // ============================================================
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tmo;
    chk_val(32'h0000_0000, 32'h0000_0001);
    close_out;
  endtask

  function automatic logic [7:0] pick(input logic [31:0] rq, input logic [7:0] lv, input bit rr);
    for (int i = 1; i < 32; i++) if (rq[i] && (!rr || i > lv)) return 8'(i);
    for (int i = 1; i < 32; i++) if (rq[i]) return 8'(i);
    return 8'h00;
  endfunction

  function automatic logic [15:0] exp_addr(input logic [1:0] lv, input logic [7:0] v);
    logic [7:0] e;
    e = !cmp_on ? v : (lv == 2'h2 ? 8'h01 : (lv == 2'h1 ? 8'h02 : 8'h03));
    return (plc_on ? cpu_int_pkg::BOOT_TABLE_BASE : cpu_int_pkg::APP_TABLE_BASE) + {8'h00, e};
  endfunction

  // ============================================================
  // bus and core tasks
  // ============================================================
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, dt};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (bvalid !== 1'h1 && n < 40) begin
      @(posedge aclk);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end
    r = bresp;
    bready <= 1'h0;
    if (n >= 40) tmo;
  endtask

  task automatic wrk(input logic [7:0] a, input logic [7:0] dt);
    key_write <= 1'h1;
    @(posedge aclk);
    key_write <= 1'h0;
    wr(a, dt);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (rvalid !== 1'h1 && n < 40) begin
      @(posedge aclk);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (n >= 40) tmo;
  endtask

  task automatic take(input logic [1:0] lv, input logic [7:0] v);
    int n;
    n = 0;
    // let the offer acknowledged at this edge fall before looking
    @(posedge aclk);
    while (irq_offer.valid !== 1'h1 && n < 20) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 20) tmo;
    chk_val({22'h0, irq_offer.level, irq_offer.vector}, {22'h0, lv, v});
    chk_val({16'h0000, taddr}, {16'h0000, exp_addr(lv, v)});
    ack_en <= 1'h1;
    @(posedge aclk);
    ack_en <= 1'h0;
  endtask

  task automatic retn;
    ret <= 1'h1;
    @(posedge aclk);
    ret <= 1'h0;
    @(posedge aclk);
  endtask

  // ============================================================
  // main sequence
  // ============================================================
  initial begin
    seed = 31;
    errors = 0;
    cmp_count = 0;
    {plc_on, cmp_on, aresetn, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {nmi_req, ret, ack_en, key_write} = 4'h0;
    ce = 1'h1;
    awaddr = 8'h00;
    araddr = 8'h00;
    awprot = 3'h0;
    arprot = 3'h0;
    wstrb = 4'hf;
    wdata = 32'h0000_0000;
    irq_req = 32'h0000_0000;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i));
      chk_val(d, 32'h0000_0000);
    end
    rd(8'h10);
    chk_resp(r, cpu_int_pkg::RESP_DECERR);
    wr(8'h10, 8'hff);
    chk_resp(r, cpu_int_pkg::RESP_DECERR);
    wstrb <= 4'h0;
    wr(8'h08, 8'haa);
    chk_resp(r, cpu_int_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    rd(8'h08);
    chk_resp(r, cpu_int_pkg::RESP_OKAY);
    chk_val(d, 32'h0000_0000);
    wr(8'h04, 8'hff);
    rd(8'h04);
    chk_val(d, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      q = $random(seed) & 32'hffff_fffe | 32'h0001_0000;
      irq_req <= q;
      take(2'h0, pick(q, 8'h00, 1'h0));
      irq_req <= 32'h0000_0000;
      retn;
    end
    wr(8'h00, 8'h61);
    rd(8'h00);
    chk_val(d, 32'h0000_0001);
    wr(8'h08, 8'h05);
    irq_req <= 32'h0000_0088;
    take(2'h0, 8'h07);
    irq_req <= 32'h0000_0000;
    retn;
    last = 8'h07;
    for (int i = 0; i < 6; i++) begin
      q = $random(seed) & 32'hffff_fffe | 32'h0001_0000;
      irq_req <= q;
      x = pick(q, last, 1'h1);
      take(2'h0, x);
      irq_req <= 32'h0000_0000;
      rd(8'h08);
      chk_val(d, {24'h00_0000, x});
      last = x;
      retn;
    end
    wr(8'h0c, 8'h09);
    irq_req <= 32'h0000_0008;
    take(2'h0, 8'h03);
    irq_req <= 32'h0000_0200;
    take(2'h1, 8'h09);
    irq_req <= 32'h0000_0000;
    nmi_req <= 1'h1;
    take(2'h2, 8'h01);
    rd(8'h04);
    chk_val(d, 32'h0000_0083);
    irq_req <= 32'h0000_0220;
    repeat (5) begin
      @(posedge aclk);
      chk_val({31'h0, irq_offer.valid}, 32'h0000_0000);
    end
    nmi_req <= 1'h0;
    irq_req <= 32'h0000_0000;
    retn;
    rd(8'h04);
    chk_val(d, 32'h0000_0003);
    retn;
    rd(8'h04);
    chk_val(d, 32'h0000_0001);
    retn;
    wr(8'h0c, 8'h00);
    irq_req <= 32'h0000_0200;
    take(2'h0, 8'h09);
    irq_req <= 32'h0000_0000;
    retn;
    wrk(8'h00, 8'h21);
    rd(8'h00);
    chk_val(d, 32'h0000_0021);
    chk_val({29'h0, cbits}, 32'h0000_0003);
    cmp_on = 1'h1;
    irq_req <= 32'h0000_0040;
    take(2'h0, 8'h06);
    irq_req <= 32'h0000_0000;
    retn;
    wrk(8'h00, 8'h61);
    rd(8'h00);
    chk_val(d, 32'h0000_0061);
    plc_on = 1'h1;
    nmi_req <= 1'h1;
    take(2'h2, 8'h01);
    nmi_req <= 1'h0;
    retn;
    rd(8'h04);
    chk_val(d, 32'h0000_0000);
    ce <= 1'h0;
    irq_req <= 32'h0000_0010;
    repeat (3) begin
      @(posedge aclk);
      chk_val({31'h0, irq_offer.valid}, 32'h0000_0000);
    end
    ce <= 1'h1;
    take(2'h0, 8'h04);
    irq_req <= 32'h0000_0000;
    retn;
    close_out;
  end
endmodule // test_cpu_interrupt_priority_regs

`default_nettype wire
